/* File: shared/tcb_pkg.sv */
// Purpose: constants shared by the timer clock-select and buffer block
// Assumes: 16-bit internal bus, word addressed, two byte lanes
// Notes: control register bit 7 is not stored and reads as one
package tcb_pkg;
    localparam int NUM_CH = 5;
    localparam int NUM_BUF = 4;
    localparam int CNT_W = 16;
    localparam int CTRL_W = 8;
    localparam int FIELD_W = 7;
    localparam int ADDR_W = 4;
    localparam int PRE_W = 3;
    localparam int BUF_CH_BASE = 3;
    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h80;
    localparam logic [CNT_W-1:0] BUF_RESET = 16'hFFFF;
    localparam logic [CNT_W-1:0] CNT_CLEAR = 16'h0000;
    // control register fields
    localparam int CTRL_RSV_BIT = 7;
    localparam int CLR_HI = 6;
    localparam int CLR_LO = 5;
    localparam int EDGE_HI = 4;
    localparam int EDGE_LO = 3;
    localparam int CSEL_HI = 2;
    localparam int CSEL_LO = 0;
    localparam logic [1:0] CLR_NONE = 2'h0;
    localparam logic [1:0] CLR_A = 2'h1;
    localparam logic [1:0] CLR_B = 2'h2;
    localparam logic [1:0] CLR_SYNC = 2'h3;
    // register addresses (word index)
    localparam logic [ADDR_W-1:0] ADDR_CTRL0 = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_BUF_BASE = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_LAST = 4'h8;
    // byte lanes
    localparam int LANE_LO = 0;
    localparam int LANE_HI = 1;
endpackage : tcb_pkg

/* File: core/tcb_channel.sv */
// Purpose: one timer channel: clock pick, edge detect, counter, compare, clear
// Assumes: external clock inputs are synchronous to ref_clk
// Notes: compare match is a one-cycle pulse on entry into equality
`timescale 1ns/100ps
module tcb_channel
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic standby,
    // configuration
    input wire logic [tcb_pkg::FIELD_W-1:0] ctrl,
    input wire logic [3:0] int_tick,
    input wire logic [3:0] ext_clk,
    input wire logic phase_mode,
    input wire logic phase_step,
    input wire logic phase_up,
    // general register side
    input wire logic [tcb_pkg::CNT_W-1:0] gr_a,
    input wire logic [tcb_pkg::CNT_W-1:0] gr_b,
    input wire logic a_is_capture,
    input wire logic b_is_capture,
    input wire logic capture_a,
    input wire logic capture_b,
    input wire logic sync_clear,
    // results
    output logic [tcb_pkg::CNT_W-1:0] count,
    output logic match_a,
    output logic match_b,
    output logic clear_req,
    output logic cleared
);
    typedef struct packed {
        logic [tcb_pkg::CNT_W-1:0] count;
        logic [3:0] ext_prev;
        logic eq_a_d;
        logic eq_b_d;
    } tcb_ch_state_t;

    localparam tcb_ch_state_t ST_RESET = '{tcb_pkg::CNT_CLEAR, 4'h0, 1'b0, 1'b0};

    tcb_ch_state_t st;
    tcb_ch_state_t next_st;
    logic [2:0] csel;
    logic [1:0] clr_sel;
    logic rise;
    logic fall;
    logic edge_tick;
    logic tick;
    logic eq_a;
    logic eq_b;
    logic ev_a;
    logic ev_b;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        csel = ctrl[tcb_pkg::CSEL_HI:tcb_pkg::CSEL_LO];
        clr_sel = ctrl[tcb_pkg::CLR_HI:tcb_pkg::CLR_LO];
        rise = ext_clk[csel[1:0]] & ~st.ext_prev[csel[1:0]];
        fall = ~ext_clk[csel[1:0]] & st.ext_prev[csel[1:0]];
        // both-edge code ignores the low edge bit
        if (ctrl[tcb_pkg::EDGE_HI])
            edge_tick = rise | fall;
        else if (ctrl[tcb_pkg::EDGE_LO])
            edge_tick = fall;
        else
            edge_tick = rise;
        // internal ticks already mark falling edges of the divided clock
        tick = csel[2] ? edge_tick : int_tick[csel[1:0]];
        eq_a = !a_is_capture && (st.count == gr_a);
        eq_b = !b_is_capture && (st.count == gr_b);
        match_a = eq_a & ~st.eq_a_d;
        match_b = eq_b & ~st.eq_b_d;
        ev_a = a_is_capture ? capture_a : match_a;
        ev_b = b_is_capture ? capture_b : match_b;
        clear_req = ((clr_sel == tcb_pkg::CLR_A) && ev_a) || ((clr_sel == tcb_pkg::CLR_B) && ev_b);
        cleared = clear_req || ((clr_sel == tcb_pkg::CLR_SYNC) && sync_clear);
        next_st = st;
        next_st.ext_prev = ext_clk;
        next_st.eq_a_d = eq_a;
        next_st.eq_b_d = eq_b;
        if (cleared)
            next_st.count = tcb_pkg::CNT_CLEAR;
        else if (phase_mode)
        begin
            // clock and edge fields have no say here
            if (phase_step)
                next_st.count = phase_up ? st.count + 16'h0001 : st.count - 16'h0001;
        end
        else if (tick)
            next_st.count = st.count + 16'h0001;
        if (standby)
            next_st = ST_RESET;
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            st <= ST_RESET;
        else if (ce)
            st <= next_st;
    end

    assign count = st.count;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    clear_to_zero_a: assert property (ce && cleared && !standby |=> count == 16'h0000)
        else $error("counter not zero after clear");
    match_equal_a: assert property (match_a |-> !a_is_capture && count == gr_a)
        else $error("compare match without equality");
    internal_hold_a: assert property (ce && !csel[2] && !phase_mode && !cleared && !standby
        && !int_tick[csel[1:0]] |=> $stable(count))
        else $error("internal clock counted off its falling edge");
    phase_up_a: assert property (ce && phase_mode && phase_step && phase_up && !cleared && !standby
        |=> count == $past(count) + 16'h0001)
        else $error("phase count did not step up");
endmodule : tcb_channel

/* File: core/tcb_timer_sel.sv */
// Purpose: five-channel timer clock/clear/edge select with channel 3-4 buffers
// Assumes: CPU internal 16-bit bus, word index address, byte lanes in bus_be
// Notes: read data arrive one cycle after bus_rd; capture beats CPU write
`timescale 1ns/100ps
module tcb_timer_sel
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic standby,
    // cpu internal bus
    input wire logic [tcb_pkg::ADDR_W-1:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [1:0] bus_be,
    input wire logic [tcb_pkg::CNT_W-1:0] bus_wdata,
    output logic [tcb_pkg::CNT_W-1:0] bus_rdata,
    // function control and mode bits
    input wire logic ch3_a_buffer_enable,
    input wire logic ch3_b_buffer_enable,
    input wire logic ch4_a_buffer_enable,
    input wire logic ch4_b_buffer_enable,
    input wire logic phase_counting_enable,
    input wire logic phase_step,
    input wire logic phase_up,
    input wire logic [tcb_pkg::NUM_CH-1:0] sync_member,
    // external clocks
    input wire logic ext_clock_in_a,
    input wire logic ext_clock_in_b,
    input wire logic ext_clock_in_c,
    input wire logic ext_clock_in_d,
    // general register side
    input wire logic [tcb_pkg::NUM_CH-1:0][tcb_pkg::CNT_W-1:0] a_side_general_register,
    input wire logic [tcb_pkg::NUM_CH-1:0][tcb_pkg::CNT_W-1:0] b_side_general_register,
    input wire logic [tcb_pkg::NUM_CH-1:0] a_capture_mode,
    input wire logic [tcb_pkg::NUM_CH-1:0] b_capture_mode,
    input wire logic [tcb_pkg::NUM_CH-1:0] capture_a,
    input wire logic [tcb_pkg::NUM_CH-1:0] capture_b,
    // counters and events
    output logic [tcb_pkg::NUM_CH-1:0][tcb_pkg::CNT_W-1:0] channel_counter,
    output logic [tcb_pkg::NUM_CH-1:0] compare_match_a,
    output logic [tcb_pkg::NUM_CH-1:0] compare_match_b,
    output logic [tcb_pkg::NUM_CH-1:0] counter_cleared,
    // general register loads from buffers, index 0 is channel 3
    output logic [1:0] gr_a_load,
    output logic [1:0] gr_b_load,
    output logic [1:0][tcb_pkg::CNT_W-1:0] gr_a_load_data,
    output logic [1:0][tcb_pkg::CNT_W-1:0] gr_b_load_data
);
    typedef struct packed {
        logic [tcb_pkg::NUM_CH-1:0][tcb_pkg::FIELD_W-1:0] ctrl;
        logic [tcb_pkg::NUM_BUF-1:0][tcb_pkg::CNT_W-1:0] buff;
        logic [tcb_pkg::PRE_W-1:0] pre;
        logic [tcb_pkg::CNT_W-1:0] rdata;
    } tcb_top_state_t;

    localparam tcb_top_state_t ST_RESET = '{
        {tcb_pkg::NUM_CH{tcb_pkg::CTRL_RESET[tcb_pkg::FIELD_W-1:0]}},
        {tcb_pkg::NUM_BUF{tcb_pkg::BUF_RESET}},
        3'h0,
        16'h0000
    };

    tcb_top_state_t st;
    tcb_top_state_t next_st;
    logic [3:0] int_tick;
    logic [3:0] ext_clk;
    logic [tcb_pkg::NUM_CH-1:0] clear_req;
    logic [tcb_pkg::NUM_BUF-1:0] buf_en;
    logic [tcb_pkg::NUM_BUF-1:0] buf_cap_mode;
    logic [tcb_pkg::NUM_BUF-1:0] buf_match;
    logic [tcb_pkg::NUM_BUF-1:0] buf_capture;
    logic [tcb_pkg::NUM_BUF-1:0][tcb_pkg::CNT_W-1:0] buf_gr;
    logic [tcb_pkg::NUM_BUF-1:0] buf_load;
    logic sync_any;

    ////////////////////////////////////////////////////////////////////////
    // prescaler: tick k marks the falling edge of the clock divided by 2^k
    assign int_tick[0] = 1'b1;
    assign int_tick[1] = st.pre[0];
    assign int_tick[2] = &st.pre[1:0];
    assign int_tick[3] = &st.pre[2:0];
    assign ext_clk = {ext_clock_in_d, ext_clock_in_c, ext_clock_in_b, ext_clock_in_a};
    assign sync_any = |(clear_req & sync_member);

    ////////////////////////////////////////////////////////////////////////
    genvar ch;
    generate
        for (ch = 0; ch < tcb_pkg::NUM_CH; ch++)
        begin : g_ch
            tcb_channel u_ch
            (
                .ref_clk(ref_clk),
                .reset_n(reset_n),
                .ce(ce),
                .standby(standby),
                .ctrl(st.ctrl[ch]),
                .int_tick(int_tick),
                .ext_clk(ext_clk),
                .phase_mode(phase_counting_enable && (ch == 2)),
                .phase_step(phase_step),
                .phase_up(phase_up),
                .gr_a(a_side_general_register[ch]),
                .gr_b(b_side_general_register[ch]),
                .a_is_capture(a_capture_mode[ch]),
                .b_is_capture(b_capture_mode[ch]),
                .capture_a(capture_a[ch]),
                .capture_b(capture_b[ch]),
                .sync_clear(sync_member[ch] && sync_any),
                .count(channel_counter[ch]),
                .match_a(compare_match_a[ch]),
                .match_b(compare_match_b[ch]),
                .clear_req(clear_req[ch]),
                .cleared(counter_cleared[ch])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // buffer pairing: index 0 A3, 1 B3, 2 A4, 3 B4
    assign buf_en = {ch4_b_buffer_enable, ch4_a_buffer_enable, ch3_b_buffer_enable, ch3_a_buffer_enable};

    genvar bi;
    generate
        for (bi = 0; bi < tcb_pkg::NUM_BUF; bi++)
        begin : g_buf
            localparam int C = tcb_pkg::BUF_CH_BASE + bi / 2;
            if (bi % 2 == 0)
            begin : g_a
                assign buf_cap_mode[bi] = a_capture_mode[C];
                assign buf_match[bi] = compare_match_a[C];
                assign buf_capture[bi] = capture_a[C];
                assign buf_gr[bi] = a_side_general_register[C];
                assign gr_a_load[bi / 2] = buf_load[bi];
                assign gr_a_load_data[bi / 2] = st.buff[bi];
            end
            else
            begin : g_b
                assign buf_cap_mode[bi] = b_capture_mode[C];
                assign buf_match[bi] = compare_match_b[C];
                assign buf_capture[bi] = capture_b[C];
                assign buf_gr[bi] = b_side_general_register[C];
                assign gr_b_load[bi / 2] = buf_load[bi];
                assign gr_b_load_data[bi / 2] = st.buff[bi];
            end
            // compare buffering: the buffer value goes to the general register
            assign buf_load[bi] = buf_en[bi] && !buf_cap_mode[bi] && buf_match[bi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_st = st;
        next_st.pre = st.pre + 3'h1;
        // control registers: low lane only, bit 7 not stored
        if (bus_wr && bus_be[tcb_pkg::LANE_LO] && bus_addr < tcb_pkg::ADDR_BUF_BASE)
            next_st.ctrl[bus_addr - tcb_pkg::ADDR_CTRL0] = bus_wdata[tcb_pkg::FIELD_W-1:0];
        for (int i = 0; i < tcb_pkg::NUM_BUF; i++)
        begin
            if (bus_wr && bus_addr == tcb_pkg::ADDR_BUF_BASE + 4'(i))
            begin
                if (bus_be[tcb_pkg::LANE_LO])
                    next_st.buff[i][7:0] = bus_wdata[7:0];
                if (bus_be[tcb_pkg::LANE_HI])
                    next_st.buff[i][15:8] = bus_wdata[15:8];
            end
            // capture buffering wins over a CPU write in the same cycle
            if (buf_en[i] && buf_cap_mode[i] && buf_capture[i])
                next_st.buff[i] = buf_gr[i];
        end
        // read path
        if (!bus_rd)
            next_st.rdata = st.rdata;
        else if (bus_addr < tcb_pkg::ADDR_BUF_BASE)
            next_st.rdata = {8'h00, tcb_pkg::CTRL_RESET[tcb_pkg::CTRL_RSV_BIT],
                st.ctrl[bus_addr - tcb_pkg::ADDR_CTRL0]};
        else if (bus_addr <= tcb_pkg::ADDR_LAST)
            next_st.rdata = st.buff[bus_addr - tcb_pkg::ADDR_BUF_BASE];
        else
            next_st.rdata = 16'h0000;
        if (standby)
            next_st = ST_RESET;
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            st <= ST_RESET;
        else if (ce)
            st <= next_st;
    end

    assign bus_rdata = st.rdata;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    ctrl_bit7_one_a: assert property (ce && bus_rd && !standby && bus_addr < 4'h5 |=> bus_rdata[7])
        else $error("control bit 7 read as zero");
    buf_standby_a: assert property (ce && standby |=> st.buff == {4{16'hFFFF}})
        else $error("buffers not FFFF after standby");
    ctrl_standby_a: assert property (ce && standby |=> st.ctrl == '0)
        else $error("control not 80 after standby");
    cmp_load_a: assert property (ch3_a_buffer_enable && !a_capture_mode[3] && compare_match_a[3]
        |-> gr_a_load[0] && gr_a_load_data[0] == st.buff[0])
        else $error("compare buffer not loaded on match");
    no_load_off_a: assert property (!ch4_b_buffer_enable |-> !gr_b_load[1])
        else $error("disabled buffer loaded general register");
    cap_shift_a: assert property (ce && !standby && ch4_b_buffer_enable && b_capture_mode[4] && capture_b[4]
        |=> st.buff[3] == $past(b_side_general_register[4]))
        else $error("capture buffer missed old value");
    byte_lane_a: assert property (ce && !standby && bus_wr && bus_be == 2'h1 && bus_addr == 4'h6
        && !(ch3_b_buffer_enable && b_capture_mode[3] && capture_b[3])
        |=> st.buff[1][15:8] == $past(st.buff[1][15:8]) && st.buff[1][7:0] == $past(bus_wdata[7:0]))
        else $error("byte write touched wrong lane");
    prescale_tick_a: assert property (ce && int_tick[3] |=> !int_tick[3] [*7])
        else $error("divide-by-eight tick too frequent");
    cmp_load_b_a: assert property (ch4_b_buffer_enable && !b_capture_mode[4] && compare_match_b[4]
        |-> gr_b_load[1] && gr_b_load_data[1] == st.buff[3])
        else $error("compare buffer B not loaded on match");
    sync_clear_a: assert property (ce && !standby && clear_req[3] && sync_member[3] && sync_member[4]
        && st.ctrl[4][tcb_pkg::CLR_HI:tcb_pkg::CLR_LO] == tcb_pkg::CLR_SYNC
        |=> channel_counter[4] == tcb_pkg::CNT_CLEAR)
        else $error("synchronized channel not cleared");
    ctrl_lane_a: assert property (ce && !standby && bus_wr && !bus_be[tcb_pkg::LANE_LO]
        && bus_addr < tcb_pkg::ADDR_BUF_BASE |=> $stable(st.ctrl))
        else $error("control changed on high-lane write");
    rdata_hold_a: assert property (ce && !bus_rd && !standby |=> $stable(bus_rdata))
        else $error("read data changed without a read");
endmodule : tcb_timer_sel

/* File: testbench/tcb_cpu_model.sv */
// Purpose: cpu master on the timer's internal register bus
// Assumes: strobes change 1 ns after a rising edge, one access per call
// Notes: idle address and data are scrambled so stale values never match
`timescale 1ns/100ps
module tcb_cpu_model
(
    // clock
    input wire logic ref_clk,
    // register bus
    output logic [tcb_pkg::ADDR_W-1:0] bus_addr,
    output logic bus_wr,
    output logic bus_rd,
    output logic [1:0] bus_be,
    output logic [tcb_pkg::CNT_W-1:0] bus_wdata,
    input wire logic [tcb_pkg::CNT_W-1:0] bus_rdata
);
    initial
    begin
        bus_addr = 4'hF;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_be = 2'h0;
        bus_wdata = 16'hA5A5;
    end

    task automatic write_reg(input logic [3:0] addr, input logic [1:0] be, input logic [15:0] data);
        @(posedge ref_clk);
        #1;
        bus_addr = addr;
        bus_be = be;
        bus_wdata = data;
        bus_wr = 1'b1;
        @(posedge ref_clk);
        #1;
        bus_wr = 1'b0;
        bus_addr = ~addr;
        bus_wdata = ~data;
    endtask : write_reg

    // read data are registered, so they are taken one edge after the strobe
    task automatic read_reg(input logic [3:0] addr, output logic [15:0] data);
        @(posedge ref_clk);
        #1;
        bus_addr = addr;
        bus_rd = 1'b1;
        @(posedge ref_clk);
        #1;
        data = bus_rdata;
        bus_rd = 1'b0;
        bus_addr = ~addr;
    endtask : read_reg
endmodule : tcb_cpu_model

/* File: testbench/tb_timer_clock_select_and_buffer.sv */
// Purpose: self-checking bench for the timer clock-select and buffer block
// Assumes: inputs change 1 ns after the rising edge
// Notes: counters are watched at the ports, registers through the cpu model
`timescale 1ns/100ps
module tb_timer_clock_select_and_buffer;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic ce = 1'b1;
    logic standby = 1'b0;
    logic [3:0] bus_addr;
    logic bus_wr, bus_rd;
    logic [1:0] bus_be;
    logic [15:0] bus_wdata, bus_rdata, rv, c0;
    logic [3:0] buf_en = 4'h0;
    logic [3:0] ext = 4'h0;
    logic phase_counting_enable = 1'b0;
    logic phase_step = 1'b0;
    logic phase_up = 1'b0;
    logic [4:0] sync_member = 5'h00;
    logic [4:0][15:0] a_side_general_register = '1;
    logic [4:0][15:0] b_side_general_register = '1;
    logic [4:0] a_capture_mode = 5'h00;
    logic [4:0] b_capture_mode = 5'h00;
    logic [4:0] capture_a = 5'h00;
    logic [4:0] capture_b = 5'h00;
    logic [4:0][15:0] channel_counter;
    logic [4:0] compare_match_a, compare_match_b, counter_cleared;
    logic [1:0] gr_a_load, gr_b_load;
    logic [1:0][15:0] gr_a_load_data, gr_b_load_data;
    int err_total = 0;
    int cmp_count = 0;

    always #5 ref_clk = ~ref_clk;

    tcb_timer_sel i_dut (.ref_clk, .reset_n, .ce, .standby, .bus_addr, .bus_wr, .bus_rd, .bus_be, .bus_wdata,
        .bus_rdata, .ch3_a_buffer_enable(buf_en[0]), .ch3_b_buffer_enable(buf_en[1]),
        .ch4_a_buffer_enable(buf_en[2]), .ch4_b_buffer_enable(buf_en[3]), .phase_counting_enable, .phase_step,
        .phase_up, .sync_member, .ext_clock_in_a(ext[0]), .ext_clock_in_b(ext[1]), .ext_clock_in_c(ext[2]),
        .ext_clock_in_d(ext[3]), .a_side_general_register, .b_side_general_register, .a_capture_mode,
        .b_capture_mode, .capture_a, .capture_b, .channel_counter, .compare_match_a, .compare_match_b,
        .counter_cleared, .gr_a_load, .gr_b_load, .gr_a_load_data, .gr_b_load_data);

    tcb_cpu_model i_cpu (.ref_clk, .bus_addr, .bus_wr, .bus_rd, .bus_be, .bus_wdata, .bus_rdata);

    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run

    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check16

    task automatic rd_check(input logic [3:0] addr, input logic [15:0] exp);
        i_cpu.read_reg(addr, rv);
        check16(rv, exp);
    endtask : rd_check

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc

    // counter must run a few counts first so a missing clear shows
    task automatic clr_chk(input int ch, input logic [15:0] ctl, input logic on_a, input logic exp0);
        i_cpu.write_reg(4'(ch), 2'h3, ctl);
        cyc(3);
        if (on_a)
            capture_a[ch] = 1'b1;
        else
            capture_b[ch] = 1'b1;
        cyc(1);
        capture_a = 5'h00;
        capture_b = 5'h00;
        check16({15'h0, channel_counter[ch] == 16'h0}, {15'h0, exp0});
    endtask : clr_chk

    task automatic wait_match(input int ch, input logic on_b);
        int n;
        logic [15:0] tgt;
        tgt = channel_counter[ch] + 16'h6;
        if (on_b)
            b_side_general_register[ch] = tgt;
        else
            a_side_general_register[ch] = tgt;
        n = 0;
        while ((on_b ? compare_match_b[ch] : compare_match_a[ch]) !== 1'b1 && n < 40)
        begin
            cyc(1);
            n++;
        end
        check16({15'h0, on_b ? compare_match_b[ch] : compare_match_a[ch]}, 16'h1);
        check16(channel_counter[ch], tgt);
    endtask : wait_match

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #100000;
        err_total++;
        complete_run();
    end

    initial
    begin
        cyc(5);
        reset_n = 1'b1;
        for (int i = 0; i < 9; i++)
            rd_check(4'(i), (i < 5) ? 16'h0080 : 16'hFFFF);
        rd_check(4'h9, 16'h0000);
        i_cpu.write_reg(4'h2, 2'h3, 16'hFFFF);
        rd_check(4'h2, 16'h00FF);
        i_cpu.write_reg(4'h2, 2'h2, 16'h0000);
        rd_check(4'h2, 16'h00FF);
        i_cpu.write_reg(4'h7, 2'h3, 16'h1234);
        i_cpu.write_reg(4'h7, 2'h1, 16'h00AB);
        rd_check(4'h7, 16'h12AB);
        i_cpu.write_reg(4'h7, 2'h2, 16'hCD00);
        rd_check(4'h7, 16'hCDAB);
        $display("test registers done");
        for (int k = 0; k < 4; k++)
        begin
            i_cpu.write_reg(4'h0, 2'h3, 16'(k));
            c0 = channel_counter[0];
            cyc(16);
            check16(channel_counter[0] - c0, 16'(16 >> k));
        end
        // divide-by-eight would count once in eight cycles if ce were ignored
        c0 = channel_counter[0];
        ce = 1'b0;
        cyc(8);
        check16(channel_counter[0], c0);
        ce = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            i_cpu.write_reg(4'h1, 2'h3, 16'((i << 3) | (4 + i)));
            c0 = channel_counter[1];
            repeat (4)
            begin
                ext[i] = ~ext[i];
                cyc(2);
            end
            check16(channel_counter[1] - c0, (i < 2) ? 16'h2 : 16'h4);
        end
        phase_counting_enable = 1'b1;
        phase_up = 1'b1;
        c0 = channel_counter[2];
        cyc(5);
        repeat (3)
        begin
            phase_step = 1'b1;
            cyc(1);
            phase_step = 1'b0;
            cyc(1);
        end
        check16(channel_counter[2] - c0, 16'h3);
        $display("test clocks done");
        i_cpu.write_reg(4'h0, 2'h3, 16'h0020);
        wait_match(0, 1'b0);
        check16({15'h0, counter_cleared[0]}, 16'h1);
        cyc(1);
        check16(channel_counter[0], 16'h0000);
        a_capture_mode[1] = 1'b1;
        b_capture_mode[1] = 1'b1;
        clr_chk(1, 16'h0040, 1'b0, 1'b1);
        clr_chk(1, 16'h0000, 1'b0, 1'b0);
        clr_chk(1, 16'h0020, 1'b0, 1'b0);
        $display("test clears done");
        buf_en[0] = 1'b1;
        i_cpu.write_reg(4'h5, 2'h3, 16'h5555);
        wait_match(3, 1'b0);
        check16({15'h0, gr_a_load[0]}, 16'h1);
        check16(gr_a_load_data[0], 16'h5555);
        buf_en[0] = 1'b0;
        cyc(2);
        wait_match(3, 1'b0);
        check16({15'h0, gr_a_load[0]}, 16'h0);
        buf_en[3] = 1'b1;
        b_capture_mode[4] = 1'b1;
        b_side_general_register[4] = 16'h4321;
        capture_b[4] = 1'b1;
        cyc(1);
        capture_b[4] = 1'b0;
        rd_check(4'h8, 16'h4321);
        buf_en[3] = 1'b0;
        b_side_general_register[4] = 16'h1111;
        capture_b[4] = 1'b1;
        cyc(1);
        capture_b[4] = 1'b0;
        rd_check(4'h8, 16'h4321);
        b_capture_mode[4] = 1'b0;
        buf_en[3] = 1'b1;
        i_cpu.write_reg(4'h8, 2'h3, 16'h2468);
        wait_match(4, 1'b1);
        check16({15'h0, gr_b_load[1]}, 16'h1);
        check16(gr_b_load_data[1], 16'h2468);
        check16({15'h0, gr_a_load[1]}, 16'h0);
        check16(gr_a_load_data[1], 16'hCDAB);
        buf_en[3] = 1'b0;
        $display("test buffers done");
        sync_member = 5'h18;
        a_capture_mode[3] = 1'b1;
        i_cpu.write_reg(4'h4, 2'h3, 16'h0060);
        clr_chk(3, 16'h0020, 1'b1, 1'b1);
        check16(channel_counter[4], 16'h0000);
        i_cpu.write_reg(4'h6, 2'h3, 16'h0000);
        i_cpu.write_reg(4'h6, 2'h1, 16'h00EE);
        rd_check(4'h6, 16'h00EE);
        standby = 1'b1;
        cyc(1);
        standby = 1'b0;
        rd_check(4'h4, 16'h0080);
        rd_check(4'h6, 16'hFFFF);
        $display("test sync and standby done");
        complete_run();
    end
endmodule : tb_timer_clock_select_and_buffer
